//--- common/sar_pkg.sv
package sar_pkg;

    // result layout
    localparam int RESULT_BITS = 18;
    localparam int BURST_SINGLE = 9;        // readout pulses, one lane
    localparam int BURST_DUAL = 5;          // readout pulses, two lanes
    localparam int DISCARD_CYCLES = 2;      // invalid conversions after wake

    // conversion timing
    localparam real CLK_PERIOD_NS = 4.0;
    localparam real CONV_TIME_NS = 63.0;
    localparam int CONV_CYCLES = int'(CONV_TIME_NS / CLK_PERIOD_NS - 0.5); // round down
    localparam logic [4:0] CONV_CNT_W1 = 5'(CONV_CYCLES - 1); // result loads CONV_CYCLES edges on
    localparam logic [4:0] CONV_CNT_RST = 5'h00;
    localparam logic [17:0] RESULT_RST = 18'h00000;

    // pins from the host
    typedef struct packed {
        logic convert_strobe;
        logic power_down_n;
        logic dual_lane_select;
        logic readout_clk;
    } sar_pins_t;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_IDLE,
        ST_CONV
    } sar_state_t;

endpackage : sar_pkg

//--- hdl/sar_readout.sv
module sar_readout
    import sar_pkg::*;
#(
    parameter int WIDTH = RESULT_BITS
) (
    // clock and power-on reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // host pins and the sampled input value
    input  wire sar_pins_t        pins,
    input  wire logic [WIDTH-1:0] sample_value,
    // link outputs
    output logic                  lane_a_out,
    output logic                  lane_b_out,
    output logic                  lane_b_enable,
    output logic                  echoed_clock_out,
    // status
    output logic                  result_valid,
    output logic                  powered
);

    // two-stage synchronisers for all host pins
    sar_pins_t meta_q;
    sar_pins_t sync_q;
    sar_pins_t prev_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges of the synchronised strobe and readout clock
    logic cnv_rise;
    logic rclk_edge;
    assign cnv_rise  = sync_q.convert_strobe & ~prev_q.convert_strobe;
    assign rclk_edge = sync_q.readout_clk ^ prev_q.readout_clk;

    // control state
    sar_state_t       state_q, state_d;
    logic [4:0]       cnt_q, cnt_d;
    logic [WIDTH-1:0] held_q, held_d;
    logic [WIDTH-1:0] shift_q, shift_d;
    logic [1:0]       warm_q, warm_d;
    logic             dual_q, dual_d;
    // next values of the outputs
    logic             lane_a_d;
    logic             lane_b_d;
    logic             lane_b_en_d;
    logic             echo_d;
    logic             valid_d;
    logic             powered_d;

    // next-state computation
    always_comb
    begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        held_d      = held_q;
        shift_d     = shift_q;
        warm_d      = warm_q;
        dual_d      = dual_q;
        lane_a_d    = lane_a_out;
        lane_b_d    = lane_b_out;
        lane_b_en_d = lane_b_enable;
        echo_d      = echoed_clock_out;
        valid_d     = result_valid;
        powered_d   = sync_q.power_down_n;
        if (!sync_q.power_down_n)
        begin
            // everything off, requests ignored
            state_d     = ST_OFF;
            warm_d      = 2'(DISCARD_CYCLES);
            lane_a_d    = 1'b0;
            lane_b_d    = 1'b0;
            lane_b_en_d = 1'b0;
            echo_d      = 1'b0;
            valid_d     = 1'b0;
        end
        else
        begin
            // readout shifting continues during a new conversion
            if (rclk_edge)
            begin
                echo_d = sync_q.readout_clk;
                if (dual_q)
                begin
                    // two lanes: next bit pair per edge
                    shift_d  = {shift_q[WIDTH-3:0], 2'b00};
                    lane_a_d = shift_q[WIDTH-3];
                    lane_b_d = shift_q[WIDTH-4];
                end
                else
                begin
                    // one lane: next bit per edge
                    shift_d  = {shift_q[WIDTH-2:0], 1'b0};
                    lane_a_d = shift_q[WIDTH-2];
                end
            end
            unique case (state_q)
                ST_OFF:
                begin
                    // wake one cycle after power returns
                    state_d = ST_IDLE;
                end
                ST_IDLE:
                begin
                    // strobe rise captures the sample
                    if (cnv_rise)
                    begin
                        held_d  = sample_value;
                        cnt_d   = CONV_CNT_W1;
                        state_d = ST_CONV;
                    end
                end
                ST_CONV:
                begin
                    if (cnt_q == CONV_CNT_RST)
                    begin
                        // load result, msb first on lane a
                        state_d     = ST_IDLE;
                        shift_d     = held_q;
                        dual_d      = sync_q.dual_lane_select;
                        lane_b_en_d = sync_q.dual_lane_select;
                        lane_a_d    = held_q[WIDTH-1];
                        lane_b_d    = sync_q.dual_lane_select & held_q[WIDTH-2];
                        valid_d     = (warm_q == 2'h0);
                        // count down the discarded conversions
                        if (warm_q != 2'h0)
                            warm_d = warm_q - 2'h1;
                    end
                    else
                    begin
                        // internal conversion clock counts down
                        cnt_d = cnt_q - 5'h01;
                    end
                end
                default:
                begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    // register everything; reset stands in for the power-on reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q          <= ST_OFF;
            cnt_q            <= CONV_CNT_RST;
            held_q           <= RESULT_RST;
            shift_q          <= RESULT_RST;
            warm_q           <= 2'(DISCARD_CYCLES);
            dual_q           <= 1'b0;
            lane_a_out       <= 1'b0;
            lane_b_out       <= 1'b0;
            lane_b_enable    <= 1'b0;
            echoed_clock_out <= 1'b0;
            result_valid     <= 1'b0;
            powered          <= 1'b0;
        end
        else
        begin
            state_q          <= state_d;
            cnt_q            <= cnt_d;
            held_q           <= held_d;
            shift_q          <= shift_d;
            warm_q           <= warm_d;
            dual_q           <= dual_d;
            lane_a_out       <= lane_a_d;
            lane_b_out       <= lane_b_d;
            lane_b_enable    <= lane_b_en_d;
            echoed_clock_out <= echo_d;
            result_valid     <= valid_d;
            powered          <= powered_d;
        end
    end

endmodule : sar_readout

//--- testbench/sar_readout_chk.sv
module sar_readout_chk
    import sar_pkg::*;
(
    // clock and reset
    input wire logic      clk,
    input wire logic      rstn,
    // watched ports
    input wire sar_pins_t pins,
    input wire logic      lane_a_out,
    input wire logic      lane_b_enable,
    input wire logic      echoed_clock_out,
    input wire logic      result_valid,
    input wire logic      powered
);
    timeunit 1ns / 1ns;
    // one clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_sleep_flag: assert property (!pins.power_down_n [*5] |-> !powered) else $error("up");
    a_wake_flag: assert property (pins.power_down_n [*6] |-> powered) else $error("down");
    a_sleep_quiet: assert property (!powered [*2] |-> !{lane_a_out, lane_b_enable,
        echoed_clock_out, result_valid}) else $error("outputs on");
    a_echo_follow: assert property (powered && pins.readout_clk != echoed_clock_out
        |-> ##[1:6] echoed_clock_out == pins.readout_clk || !powered) else $error("echo");
    a_wake_warm: assert property ($rose(powered) |-> !result_valid [*8]) else $error("warm");
    a_valid_power: assert property (result_valid |-> powered) else $error("valid");
    a_dual_power: assert property (lane_b_enable |-> powered) else $error("lane b");
    a_reset_out: assert property ($rose(rstn) |-> !powered && !result_valid) else $error("rst");
endmodule : sar_readout_chk

bind sar_readout sar_readout_chk u_chk (.clk, .rstn, .pins, .lane_a_out, .lane_b_enable,
    .echoed_clock_out, .result_valid, .powered);

//--- testbench/sar_host_mdl.sv
module sar_host_mdl
    import sar_pkg::*;
(
    // clock and link returns
    input wire logic      clk,
    input wire logic      lane_a_out,
    input wire logic      lane_b_out,
    input wire logic      echoed_clock_out,
    // pins toward the converter
    output sar_pins_t     pins
);
    timeunit 1ns / 1ns;
    // pins idle low, converter asleep
    initial pins = '0;
    // power pin, short settle instead of the long one
    task automatic power(input logic on);
        #1 pins.power_down_n = on;
        repeat (8) @(posedge clk);
    endtask : power
    // strobe, wait out the conversion, burst the readout clock
    task automatic xfer(input logic dual, input int pulses, output logic [17:0] w);
        #1 pins.dual_lane_select = dual;
        pins.convert_strobe = 1'b1;
        repeat (5) @(posedge clk);
        #1 pins.convert_strobe = 1'b0;
        repeat (24) @(posedge clk);
        #1;
        for (int e = 0; e < 2 * pulses; e++)
        begin
            if (e < (dual ? 9 : 18))
                w = dual ? {w[15:0], lane_a_out, lane_b_out} : {w[16:0], lane_a_out};
            repeat (20) @(posedge clk);
            #1 pins.readout_clk = ~pins.readout_clk;
            wait (echoed_clock_out === pins.readout_clk);
            #1;
        end
    endtask : xfer
endmodule : sar_host_mdl

//--- testbench/tb.sv
module tb
    import sar_pkg::*;
;
    timeunit 1ns / 1ns;
    // stimulus, outputs, counters
    logic        clk = 1'b0, rstn = 1'b0, lane_a_out, lane_b_out, lane_b_enable;
    logic        echoed_clock_out, result_valid, powered;
    logic [17:0] sample_value = 18'h00000, got;
    sar_pins_t   pins;
    int          mismatches = 0, n_tests = 0, cycles = 0;
    sar_readout u_dut (.clk, .rstn, .pins, .sample_value, .lane_a_out, .lane_b_out,
        .lane_b_enable, .echoed_clock_out, .result_valid, .powered);
    sar_host_mdl u_host (.clk, .lane_a_out, .lane_b_out, .echoed_clock_out, .pins);
    // clock and hang guard
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cycles == 20000) close_out(1'b1);
    // compare and count
    task automatic check(input logic [17:0] seen, exp, input string what);
        n_tests++;
        mismatches += int'(seen !== exp);
        if (seen !== exp) $display("BAD %s expected %h seen %h", what, exp, seen);
    endtask : check
    // verdict
    task automatic close_out(input bit hung);
        mismatches += hung;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // three conversions after wake, third one valid
    task automatic t_warm();
        for (int k = 0; k < 3; k++)
        begin
            sample_value = 18'h2a5c3 + 18'(k);
            u_host.xfer(1'b0, BURST_SINGLE, got);
            check(18'(result_valid), 18'(k >= DISCARD_CYCLES), "valid");
        end
        check(got, 18'h2a5c5, "word");
    endtask : t_warm
    // two-lane readout
    task automatic t_dual();
        sample_value = 18'h1b4e7;
        u_host.xfer(1'b1, BURST_DUAL, got);
        check(got, 18'h1b4e7, "dual word");
        check(18'(lane_b_enable), 18'h00001, "lane b on");
    endtask : t_dual
    // strobe while asleep is ignored, then warm-up again
    task automatic t_sleep();
        u_host.power(1'b0);
        u_host.xfer(1'b0, 0, got);
        check(18'({powered, result_valid, lane_a_out, echoed_clock_out}), 18'h00000, "off");
        u_host.power(1'b1);
        t_warm();
    endtask : t_sleep
    // reset, wake, scenarios
    initial
    begin
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        u_host.power(1'b1);
        t_warm();
        t_dual();
        t_sleep();
        close_out(1'b0);
    end
endmodule : tb
